// ==== core/dcf_pkg.sv ====
// Operation
// - Each port's width code picks 4k x 1, 2k x 2, 1k x 4, 512 x 9 or 256 x 18, and codes 5 to 7 are reserved.
// - Each port works only while its active-low block select is held low.
// - While the read block select is high the read data output keeps its last value.
// - Write enable defaults to active low and read enable to active high, each polarity selectable.
// - Writes and reads both follow the one common core clock.
// - With the pipeline select low, read data appear in the clock cycle after the read.
// - With the pipeline select high, read data appear two clock cycles after the read.
// - Reset clears the control logic and forces the output hold registers to zero.
// - Reset leaves the stored words in the memory array untouched.
// - While reset is asserted all read and write requests are ignored.
// - Write data are 18 bits wide and only the low bits of the configured width count.
// - Almost-full and almost-empty thresholds are held and compared in data bits.
// - An option chooses whether the pointers stop or keep moving at full or empty; the count saturates either way.
package dcf_pkg;

  localparam int unsigned DATA_W = 18;
  localparam int unsigned BIT_CAP = 4608;
  localparam int unsigned PTR_W = 13;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned REG_W = 32;

  localparam logic [PTR_W-1:0] CAP_SMALL = 13'h1000;
  localparam logic [PTR_W-1:0] CAP_LARGE = 13'h1200;

  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_AF_TH = 4'h4;
  localparam logic [ADDR_W-1:0] REG_AE_TH = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'hC;

  localparam int unsigned CTRL_WCODE_LSB = 0;
  localparam int unsigned CTRL_RCODE_LSB = 3;
  localparam int unsigned CTRL_WEN_AH_BIT = 6;
  localparam int unsigned CTRL_REN_AH_BIT = 7;
  localparam int unsigned CTRL_PIPE_BIT = 8;
  localparam int unsigned CTRL_STOP_BIT = 9;

  localparam int unsigned STAT_EMPTY_BIT = 13;
  localparam int unsigned STAT_FULL_BIT = 14;
  localparam int unsigned STAT_AE_BIT = 15;
  localparam int unsigned STAT_AF_BIT = 16;

  localparam logic [2:0] CODE_LAST = 3'h4;
  localparam logic [2:0] RST_WCODE = 3'h4;
  localparam logic [2:0] RST_RCODE = 3'h4;
  localparam logic RST_WEN_AH = 1'h0;
  localparam logic RST_REN_AH = 1'h1;
  localparam logic RST_PIPE = 1'h0;
  localparam logic RST_STOP = 1'h1;
  localparam logic [PTR_W-1:0] RST_AF_TH = 13'h1200;
  localparam logic [PTR_W-1:0] RST_AE_TH = 13'h0000;

  typedef struct packed {
    logic [2:0] write_width_code;
    logic [2:0] read_width_code;
    logic wen_active_high;
    logic ren_active_high;
    logic read_pipeline_select;
    logic stop_at_limit;
    logic [PTR_W-1:0] af_thresh;
    logic [PTR_W-1:0] ae_thresh;
  } dcf_cfg_s;

  typedef struct packed {
    logic full;
    logic empty;
    logic almost_full;
    logic almost_empty;
  } dcf_flags_s;

  typedef struct packed {
    logic [BIT_CAP-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W-1:0] count;
    dcf_cfg_s cfg;
    logic [DATA_W-1:0] stage;
    logic stage_valid;
    logic [DATA_W-1:0] rdata;
    dcf_flags_s flags;
    logic [REG_W-1:0] reg_rdata;
  } dcf_state_s;

  function automatic logic [4:0] width_of(input logic [2:0] code);
    case (code)
      3'h0: return 5'h01;
      3'h1: return 5'h02;
      3'h2: return 5'h04;
      3'h3: return 5'h09;
      default: return 5'h12;
    endcase
  endfunction : width_of

  function automatic logic [PTR_W-1:0] cap_of(input logic [2:0] code);
    return (code >= 3'h3) ? CAP_LARGE : CAP_SMALL;
  endfunction : cap_of

endpackage : dcf_pkg

// ==== core/dcf_fifo.sv ====
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module dcf_fifo (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic write_port_select_n_i,
  input wire logic write_enable_i,
  input wire logic [dcf_pkg::DATA_W-1:0] write_data_in_i,
  input wire logic read_port_select_n_i,
  input wire logic read_enable_i,
  output logic [dcf_pkg::DATA_W-1:0] read_data_o,
  output logic full_o,
  output logic empty_o,
  output logic almost_full_o,
  output logic almost_empty_o,
  input wire logic [dcf_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [dcf_pkg::REG_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [dcf_pkg::REG_W-1:0] reg_rdata_o
);

  dcf_pkg::dcf_state_s st_r;
  dcf_pkg::dcf_state_s st_nxt;

  logic wr_req;
  logic rd_req;
  logic wr_ok;
  logic rd_ok;
  logic [4:0] wwidth;
  logic [4:0] rwidth;
  logic [dcf_pkg::PTR_W-1:0] wcap;
  logic [dcf_pkg::PTR_W-1:0] wptr_adv;
  logic [dcf_pkg::PTR_W-1:0] rptr_adv;
  logic [dcf_pkg::PTR_W+1:0] cnt_calc;
  logic [dcf_pkg::DATA_W-1:0] rd_word;
  logic [2:0] new_wcode;
  logic [2:0] new_rcode;

  ////////////////////////////////////////////////////////////////////////////
  // Port qualification
  always_comb begin
    wwidth = dcf_pkg::width_of(st_r.cfg.write_width_code);
    rwidth = dcf_pkg::width_of(st_r.cfg.read_width_code);
    wcap = dcf_pkg::cap_of(st_r.cfg.write_width_code);
    // Enable polarity is a plain XNOR against the selected active level
    wr_req = ~write_port_select_n_i
           & (st_r.cfg.wen_active_high ? write_enable_i : ~write_enable_i);
    rd_req = ~read_port_select_n_i
           & (st_r.cfg.ren_active_high ? read_enable_i : ~read_enable_i);
    // Stop mode refuses pushes at full and pops at empty
    wr_ok = nrst_i & wr_req & (~st_r.cfg.stop_at_limit | ~st_r.flags.full);
    rd_ok = nrst_i & rd_req & (~st_r.cfg.stop_at_limit | ~st_r.flags.empty);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit-addressed word extraction and pointer stepping
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < dcf_pkg::DATA_W; i++) begin
      if (i < int'(rwidth) && (int'(st_r.rptr) + i) < int'(dcf_pkg::BIT_CAP)) begin
        rd_word[i] = st_r.mem[int'(st_r.rptr) + i];
      end
    end
    wptr_adv = st_r.wptr + dcf_pkg::PTR_W'(wwidth);
    if (wptr_adv >= wcap) begin
      wptr_adv = '0;
    end
    rptr_adv = st_r.rptr + dcf_pkg::PTR_W'(rwidth);
    if (rptr_adv >= wcap) begin
      rptr_adv = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    cnt_calc = {2'h0, st_r.count};
    new_wcode = reg_wdata_i[dcf_pkg::CTRL_WCODE_LSB +: 3];
    new_rcode = reg_wdata_i[dcf_pkg::CTRL_RCODE_LSB +: 3];

    // Writes land in the array; the width mask keeps unused upper bits out
    if (wr_ok) begin
      for (int i = 0; i < dcf_pkg::DATA_W; i++) begin
        if (i < int'(wwidth) && (int'(st_r.wptr) + i) < int'(dcf_pkg::BIT_CAP)) begin
          st_nxt.mem[int'(st_r.wptr) + i] = write_data_in_i[i];
        end
      end
      st_nxt.wptr = wptr_adv;
      cnt_calc = cnt_calc + {10'h000, wwidth};
    end

    // Pending pipelined word is delivered only while the read port is selected
    if (st_r.stage_valid && !read_port_select_n_i) begin
      st_nxt.rdata = st_r.stage;
      st_nxt.stage_valid = 1'b0;
    end
    if (rd_ok) begin
      st_nxt.rptr = rptr_adv;
      if (st_r.cfg.read_pipeline_select) begin
        st_nxt.stage = rd_word;
        st_nxt.stage_valid = 1'b1;
      end else begin
        st_nxt.rdata = rd_word;
      end
      cnt_calc = (cnt_calc > {10'h000, rwidth}) ? cnt_calc - {10'h000, rwidth} : '0;
    end

    // Continue mode keeps the pointers moving but the count saturates
    if (cnt_calc > {2'h0, wcap}) begin
      cnt_calc = {2'h0, wcap};
    end
    st_nxt.count = cnt_calc[dcf_pkg::PTR_W-1:0];

    // Register port writes; reserved width codes are refused
    if (reg_wr_i) begin
      case (reg_addr_i)
        dcf_pkg::REG_CTRL: begin
          if (new_wcode <= dcf_pkg::CODE_LAST) begin
            st_nxt.cfg.write_width_code = new_wcode;
          end
          if (new_rcode <= dcf_pkg::CODE_LAST) begin
            st_nxt.cfg.read_width_code = new_rcode;
          end
          st_nxt.cfg.wen_active_high = reg_wdata_i[dcf_pkg::CTRL_WEN_AH_BIT];
          st_nxt.cfg.ren_active_high = reg_wdata_i[dcf_pkg::CTRL_REN_AH_BIT];
          st_nxt.cfg.read_pipeline_select = reg_wdata_i[dcf_pkg::CTRL_PIPE_BIT];
          st_nxt.cfg.stop_at_limit = reg_wdata_i[dcf_pkg::CTRL_STOP_BIT];
        end
        dcf_pkg::REG_AF_TH: st_nxt.cfg.af_thresh = reg_wdata_i[dcf_pkg::PTR_W-1:0];
        dcf_pkg::REG_AE_TH: st_nxt.cfg.ae_thresh = reg_wdata_i[dcf_pkg::PTR_W-1:0];
        default: ;
      endcase
    end

    // Read data stand for exactly the cycle after the strobe
    st_nxt.reg_rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        dcf_pkg::REG_CTRL: begin
          st_nxt.reg_rdata[dcf_pkg::CTRL_WCODE_LSB +: 3] = st_r.cfg.write_width_code;
          st_nxt.reg_rdata[dcf_pkg::CTRL_RCODE_LSB +: 3] = st_r.cfg.read_width_code;
          st_nxt.reg_rdata[dcf_pkg::CTRL_WEN_AH_BIT] = st_r.cfg.wen_active_high;
          st_nxt.reg_rdata[dcf_pkg::CTRL_REN_AH_BIT] = st_r.cfg.ren_active_high;
          st_nxt.reg_rdata[dcf_pkg::CTRL_PIPE_BIT] = st_r.cfg.read_pipeline_select;
          st_nxt.reg_rdata[dcf_pkg::CTRL_STOP_BIT] = st_r.cfg.stop_at_limit;
        end
        dcf_pkg::REG_AF_TH: st_nxt.reg_rdata[dcf_pkg::PTR_W-1:0] = st_r.cfg.af_thresh;
        dcf_pkg::REG_AE_TH: st_nxt.reg_rdata[dcf_pkg::PTR_W-1:0] = st_r.cfg.ae_thresh;
        dcf_pkg::REG_STATUS: begin
          st_nxt.reg_rdata[dcf_pkg::PTR_W-1:0] = st_r.count;
          st_nxt.reg_rdata[dcf_pkg::STAT_EMPTY_BIT] = st_r.flags.empty;
          st_nxt.reg_rdata[dcf_pkg::STAT_FULL_BIT] = st_r.flags.full;
          st_nxt.reg_rdata[dcf_pkg::STAT_AE_BIT] = st_r.flags.almost_empty;
          st_nxt.reg_rdata[dcf_pkg::STAT_AF_BIT] = st_r.flags.almost_full;
        end
        default: st_nxt.reg_rdata = '0;
      endcase
    end

    // Flags follow the next count so the outputs stay registered
    st_nxt.flags.full = (dcf_pkg::PTR_W'(wwidth) > (wcap - st_nxt.count));
    st_nxt.flags.empty = (st_nxt.count < dcf_pkg::PTR_W'(rwidth));
    st_nxt.flags.almost_full = (st_nxt.count >= st_nxt.cfg.af_thresh);
    st_nxt.flags.almost_empty = (st_nxt.count <= st_nxt.cfg.ae_thresh);

    // Reset clears control and outputs; the array keeps its contents
    if (!nrst_i) begin
      st_nxt = '0;
      st_nxt.mem = st_r.mem;
      st_nxt.cfg.write_width_code = dcf_pkg::RST_WCODE;
      st_nxt.cfg.read_width_code = dcf_pkg::RST_RCODE;
      st_nxt.cfg.wen_active_high = dcf_pkg::RST_WEN_AH;
      st_nxt.cfg.ren_active_high = dcf_pkg::RST_REN_AH;
      st_nxt.cfg.read_pipeline_select = dcf_pkg::RST_PIPE;
      st_nxt.cfg.stop_at_limit = dcf_pkg::RST_STOP;
      st_nxt.cfg.af_thresh = dcf_pkg::RST_AF_TH;
      st_nxt.cfg.ae_thresh = dcf_pkg::RST_AE_TH;
      st_nxt.flags.empty = 1'b1;
      st_nxt.flags.almost_empty = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st_r <= st_nxt;
  end

  assign read_data_o = st_r.rdata;
  assign full_o = st_r.flags.full;
  assign empty_o = st_r.flags.empty;
  assign almost_full_o = st_r.flags.almost_full;
  assign almost_empty_o = st_r.flags.almost_empty;
  assign reg_rdata_o = st_r.reg_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  port_select_gate_a: assert property (
    write_port_select_n_i && nrst_i |=> st_r.wptr == $past(st_r.wptr))
    else $error("write pointer moved while write port deselected");

  read_hold_a: assert property (
    read_port_select_n_i |=> $stable(read_data_o))
    else $error("read data changed while read port deselected");

  write_polarity_a: assert property (
    !st_r.cfg.wen_active_high && !write_port_select_n_i && !write_enable_i && !full_o
    |=> st_r.wptr != $past(st_r.wptr))
    else $error("active-low write enable did not push");

  flow_read_a: assert property (
    rd_ok && !st_r.cfg.read_pipeline_select |=> read_data_o == $past(rd_word))
    else $error("unpipelined read data not presented after the read");

  piped_read_a: assert property (
    rd_ok && st_r.cfg.read_pipeline_select ##1 !read_port_select_n_i
    |=> read_data_o == $past(rd_word, 2))
    else $error("pipelined read data not one cycle later");

  reset_clear_a: assert property (disable iff (1'b0)
    !nrst_i |=> read_data_o == '0 && st_r.count == '0 && empty_o && !full_o)
    else $error("reset did not clear control and outputs");

  // Checked from a running state: before the first writes the array is still unknown
  mem_keep_a: assert property (disable iff (1'b0)
    !nrst_i && $past(nrst_i) |=> st_r.mem == $past(st_r.mem))
    else $error("reset disturbed stored words");

  reset_ignore_a: assert property (disable iff (1'b0)
    !nrst_i ##1 !nrst_i |-> st_r.wptr == '0 && st_r.rptr == '0)
    else $error("request taken during reset");

  stop_full_a: assert property (
    st_r.cfg.stop_at_limit && full_o |=> st_r.wptr == $past(st_r.wptr))
    else $error("write accepted at full in stop mode");

  stop_empty_a: assert property (
    st_r.cfg.stop_at_limit && empty_o && nrst_i |=> st_r.rptr == $past(st_r.rptr))
    else $error("read accepted at empty in stop mode");

  read_gate_a: assert property (
    read_port_select_n_i && nrst_i |=> st_r.rptr == $past(st_r.rptr))
    else $error("read pointer moved while read port deselected");

  flags_apart_a: assert property (
    !(full_o && empty_o))
    else $error("full and empty shown together");

  almost_bits_a: assert property (
    almost_full_o == (st_r.count >= st_r.cfg.af_thresh))
    else $error("almost full disagrees with bit threshold");

  reserved_code_a: assert property (
    reg_wr_i && reg_addr_i == dcf_pkg::REG_CTRL && reg_wdata_i[2:0] > dcf_pkg::CODE_LAST
    |=> $stable(st_r.cfg.write_width_code))
    else $error("reserved width code accepted");

  // A full drain takes one read per stored word, so the window spans the 256-word 18-bit shape
  fill_up_c: cover property (full_o ##[1:300] empty_o);
  piped_read_c: cover property (rd_ok && st_r.cfg.read_pipeline_select ##2 rd_ok);
  hold_c: cover property (st_r.stage_valid && read_port_select_n_i);
  cont_read_c: cover property (!st_r.cfg.stop_at_limit && empty_o && rd_ok);
  stop_drop_c: cover property (st_r.cfg.stop_at_limit && full_o && wr_req);

endmodule : dcf_fifo

// ==== tb/dcf_user.sv ====
`timescale 1ns/1ps
module dcf_user (
  input wire logic core_clk_i,
  output logic wsel_n_o,
  output logic wen_o,
  output logic [17:0] wdata_o,
  output logic rsel_n_o,
  output logic ren_o
);
  logic wen_ah = 1'b0;
  logic ren_ah = 1'b1;
  logic [2:0] wcode = 3'h4;
  logic [17:0] last_w = 18'h0;
  initial begin
    wsel_n_o = 1'b1;
    wen_o = 1'b1;
    wdata_o = 18'h3FFFF;
    rsel_n_o = 1'b1;
    ren_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [17:0] mask_of(input logic [2:0] c);
    case (c)
      3'h0: return 18'h00001;
      3'h1: return 18'h00003;
      3'h2: return 18'h0000F;
      3'h3: return 18'h001FF;
      default: return 18'h3FFFF;
    endcase
  endfunction : mask_of
  // Released data lines show the inverse word, so stale bits never pass as valid
  task automatic wr(input logic [17:0] d, input bit hold);
    last_w = d & mask_of(wcode);
    wdata_o <= last_w;
    wsel_n_o <= 1'b0;
    wen_o <= wen_ah;
    @(posedge core_clk_i);
    if (!hold) begin
      wsel_n_o <= 1'b1;
      wen_o <= ~wen_ah;
      wdata_o <= ~last_w & mask_of(wcode);
      @(posedge core_clk_i);
    end
  endtask : wr
  task automatic rd(input bit hold);
    rsel_n_o <= 1'b0;
    ren_o <= ren_ah;
    @(posedge core_clk_i);
    if (!hold) begin
      ren_o <= ~ren_ah;
      // Select stays low one more cycle so a pipelined word can land
      @(posedge core_clk_i);
      rsel_n_o <= 1'b1;
      @(posedge core_clk_i);
    end
  endtask : rd
  // Enable at its active level while the port stays deselected
  task automatic arm_rd();
    ren_o <= ren_ah;
  endtask : arm_rd
endmodule : dcf_user

// ==== tb/dual_clock_block_fifo_tb.sv ====
`timescale 1ns/1ps
module dual_clock_block_fifo_tb;
  typedef struct {int unsigned due; bit kind; logic [31:0] val;} dcf_note_s;
  logic core_clk;
  logic nrst;
  logic [dcf_pkg::ADDR_W-1:0] raddr;
  logic [dcf_pkg::REG_W-1:0] rwdata;
  logic rwr;
  logic rrd;
  logic [dcf_pkg::REG_W-1:0] rrdata;
  logic wsel_n;
  logic wen;
  logic [dcf_pkg::DATA_W-1:0] wdata;
  logic rsel_n;
  logic ren;
  logic [dcf_pkg::DATA_W-1:0] rdata;
  logic full;
  logic empty;
  logic afull;
  logic aempty;
  int unsigned cyc = 0;
  int mismatches = 0;
  int n_checks = 0;
  int seed = 32'h54E2D63C;
  logic pipe = 1'b0;
  logic [31:0] last_rd = 32'h0;
  logic [17:0] a_word;
  dcf_note_s notes[$];
  logic [17:0] words[$];
  ////////////////////////////////////////////////////////////////////////////
  dcf_fifo u_dut (.core_clk_i(core_clk), .nrst_i(nrst), .write_port_select_n_i(wsel_n),
    .write_enable_i(wen), .write_data_in_i(wdata), .read_port_select_n_i(rsel_n),
    .read_enable_i(ren), .read_data_o(rdata), .full_o(full), .empty_o(empty),
    .almost_full_o(afull), .almost_empty_o(aempty), .reg_addr_i(raddr),
    .reg_wdata_i(rwdata), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rrdata));
  dcf_user u_user (.core_clk_i(core_clk), .wsel_n_o(wsel_n), .wen_o(wen), .wdata_o(wdata),
    .rsel_n_o(rsel_n), .ren_o(ren));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    // A result still waiting in the queue was never compared
    mismatches += notes.size();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // Results are due a fixed number of edges after the request, per the hand-over timing
  always @(posedge core_clk) begin
    #1;
    cyc = cyc + 1;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      if (notes[0].kind) chk({14'h0, rdata}, notes[0].val);
      else chk(rrdata, notes[0].val);
      void'(notes.pop_front());
    end
  end
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    raddr <= a;
    rwdata <= d;
    rwr <= 1'b1;
    @(posedge core_clk);
    rwr <= 1'b0;
    @(posedge core_clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    notes.push_back('{cyc + 2, 1'b0, e});
    raddr <= a;
    rrd <= 1'b1;
    @(posedge core_clk);
    rrd <= 1'b0;
    @(posedge core_clk);
  endtask : reg_rd
  task automatic fill(input int n);
    logic [31:0] d;
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      words.push_back(d[17:0] & u_user.mask_of(u_user.wcode));
      u_user.wr(d[17:0], i != n - 1);
    end
  endtask : fill
  task automatic drain();
    while (words.size() > 0) begin
      last_rd = {14'h0, words.pop_front()};
      notes.push_back('{cyc + (pipe ? 3 : 2), 1'b1, last_rd});
      u_user.rd(words.size() > 0);
    end
  endtask : drain
  task automatic look(input logic [3:0] f, input logic [31:0] r);
    #1;
    chk({28'h0, full, empty, afull, aempty}, {28'h0, f});
    chk({14'h0, rdata}, r);
    @(posedge core_clk);
  endtask : look
  task automatic pulse_reset(input bit try_write);
    nrst <= 1'b0;
    if (try_write) u_user.wr(18'h2AAAA, 1'b0);
    else repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
  endtask : pulse_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    close_out();
  end
  initial begin
    nrst = 1'b0;
    raddr = 4'h0;
    rwdata = 32'h0;
    rwr = 1'b0;
    rrd = 1'b0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    look(4'h5, 32'h0);
    reg_rd(dcf_pkg::REG_CTRL, 32'h2A4);
    reg_rd(dcf_pkg::REG_AF_TH, 32'h1200);
    reg_rd(dcf_pkg::REG_AE_TH, 32'h0);
    reg_rd(dcf_pkg::REG_STATUS, 32'hA000);
    reg_wr(4'h2, 32'hFFFFFFFF);
    reg_rd(4'h2, 32'h0);
    reg_rd(dcf_pkg::REG_CTRL, 32'h2A4);
    reg_wr(dcf_pkg::REG_AF_TH, 32'hB4);
    reg_wr(dcf_pkg::REG_AE_TH, 32'h24);
    fill(2);
    look(4'h1, 32'h0);
    fill(1);
    look(4'h0, 32'h0);
    fill(253);
    look(4'hA, 32'h0);
    u_user.wr(18'h15555, 1'b0);
    reg_rd(dcf_pkg::REG_STATUS, 32'h15200);
    drain();
    look(4'h5, last_rd);
    for (int c = 0; c < 4; c++) begin
      pipe = c[0];
      reg_wr(dcf_pkg::REG_CTRL, 32'h280 | (c << 8 & 32'h100) | (c << 3) | c);
      u_user.wcode = c[2:0];
      fill(4);
      drain();
      look(4'h5, last_rd);
    end
    pipe = 1'b0;
    reg_wr(dcf_pkg::REG_CTRL, 32'h26D);
    reg_rd(dcf_pkg::REG_CTRL, 32'h25B);
    u_user.wen_ah = 1'b1;
    u_user.ren_ah = 1'b0;
    fill(3);
    drain();
    fill(1);
    u_user.arm_rd();
    repeat (3) @(posedge core_clk);
    look(4'h1, last_rd);
    drain();
    u_user.wen_ah = 1'b0;
    u_user.ren_ah = 1'b1;
    u_user.wcode = 3'h4;
    pulse_reset(1'b1);
    look(4'h5, 32'h0);
    reg_rd(dcf_pkg::REG_STATUS, 32'hA000);
    fill(1);
    a_word = words.pop_front();
    pulse_reset(1'b0);
    reg_wr(dcf_pkg::REG_CTRL, 32'h0A4);
    words.push_back(a_word);
    drain();
    look(4'h5, {14'h0, a_word});
    repeat (4) @(posedge core_clk);
    close_out();
  end
endmodule : dual_clock_block_fifo_tb
